// File: dv/cpa_host.sv
// Host model that pulls the shared alert line low on request.
`timescale 1ns/100ps
module cpa_host (
    input  wire logic clock_in,
    input  wire logic dev_pull_in,
    input  wire logic req_in,
    input  int        len_in,
    output logic      line_out
);
    int cnt_r = 0;
    // The pull-up is weak, so whichever party pulls low wins.
    assign line_out = !(dev_pull_in || cnt_r != 0);
    always @(posedge clock_in) begin
        if (req_in) begin
            cnt_r <= len_in;
        end else if (cnt_r != 0) begin
            cnt_r <= cnt_r - 1;
        end
    end
endmodule

// File: dv/cpa_protect_tb.sv
// Self-checking bench for the protection and alert block.
`timescale 1ns/100ps
module cpa_protect_tb;
    import cpa_pkg::*;
    logic clk = 0;
    logic rstn, dm, sm, ovl, sev, uv, rok, inov, ceil, bsh, ig, ifl, cd;
    logic cs, flt, line, req, bat, byp, rvs, hic, ln, oe, bias, rexp;
    logic pb = 1, ph = 0, ph2 = 0, pbs = 0;
    logic [1:0] hs, os;
    logic [7:0] lf = 8'h0B;
    int mismatches = 0, checks_done = 0, w = 0, cyc = 0, hlen;
    int q[$];
    always #2 clk = ~clk;
    cpa_protect #(.DCUT_CYC(10), .RETRY_CYC(20), .SDLY_CYC(8), .HIC_CYC(30),
        .PULSE_CYC(5), .PWD_CYC(40), .HOLD_STEP(10), .OFF_STEP(20)) dut_u (
        .clock_in(clk), .rstn_in(rstn), .discharge_mode_in(dm),
        .supplement_mode_in(sm), .bat_over_limit_in(ovl),
        .severe_discharge_level_in(sev), .battery_undervoltage_in(uv),
        .system_rail_ok_in(rok), .in_over_protect_in(inov),
        .input_current_ceiling_in(ceil), .bat_short_in(bsh),
        .input_good_in(ig), .input_fault_in(ifl), .charge_done_in(cd),
        .charge_status_in(cs), .fault_in(flt), .alert_line_n_in(line),
        .disconnect_hold_setting_in(hs), .disconnect_off_setting_in(os),
        .bat_switch_en_out(bat), .bypass_en_out(byp),
        .reverse_block_fet_en_out(rvs), .hiccup_out(hic),
        .alert_line_n_out(ln), .alert_line_n_oe_out(oe),
        .alert_bias_low_out(bias));
    cpa_host host_u (.clock_in(clk), .dev_pull_in(oe), .req_in(req),
        .len_in(hlen), .line_out(line));
    function automatic logic [7:0] lfsr(logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic check(logic [31:0] s, logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %0t seen %0d expected %0d", $time, s, e);
        end
    endtask
    task automatic note(int c);
        int e = -1;
        if (q.size() != 0) e = q.pop_front();
        check(c, e);
    endtask
    // Waits for every noted result, bounded so a silent design cannot hang.
    task automatic drain;
        int k = 0;
        while (q.size() != 0 && k < 3000) begin
            tick(1);
            k++;
        end
        check(q.size(), 0);
        q.delete();
        tick(60);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            print_verdict();
        end else if (rstn) begin
            if (oe === 1'b1) begin
                w <= w + 1;
                check(ln, 0);
            end else if (w != 0) begin
                note(100 + w);
                w <= 0;
            end
            if (pb && bat === 1'b0 && !hic && !bias) begin
                note(2);
            end
            if (hic === 1'b1 && !ph) begin
                note(3);
            end
            if (ph && !ph2) begin
                check(rvs, rexp);
                check(byp, 0);
            end
            if (bias === 1'b1 && !pbs) begin
                note(4);
                check(byp, 0);
            end
            if (bias === 1'b0 && pbs) begin
                note(5);
                check(bat, 1);
            end
            pb <= bat;
            ph <= hic;
            ph2 <= ph;
            pbs <= bias;
        end
    end
    initial begin
        {rstn, dm, sm, ovl, sev, uv, inov, ceil, bsh, ig} <= 10'h000;
        {ifl, cd, cs, flt, req, hs, os} <= 9'h000;
        rok <= 1'b1;
        rexp <= 1'b1;
        hlen <= 0;
        tick(16);
        rstn <= 1;
        tick(5);
        dm <= 1;
        q.push_back(2); sev <= 1; tick(10); sev <= 0; drain();
        dm <= 0;
        sm <= 1;
        q.push_back(3); ovl <= 1; tick(14); ovl <= 0; drain();
        sm <= 0;
        // Severe current outside both modes must leave the switch alone.
        sev <= 1; tick(10); sev <= 0; drain();
        q.push_back(2); uv <= 1; tick(10); uv <= 0; drain();
        // A short that outlasts one interval must start a second hiccup.
        q.push_back(3); q.push_back(3); bsh <= 1; tick(40);
        bsh <= 0; drain();
        rexp <= 0;
        q.push_back(3); rok <= 0; inov <= 1; tick(4);
        rok <= 1; inov <= 0; drain();
        q.push_back(2); q.push_back(3); rok <= 0; ceil <= 1; tick(14);
        rok <= 1; ceil <= 0; drain();
        // A shared short trips both paths but must yield a single hiccup.
        q.push_back(3); rok <= 0; inov <= 1; bsh <= 1; tick(4);
        rok <= 1; inov <= 0; bsh <= 0; drain();
        for (int i = 0; i < 5; i++) begin
            q.push_back(105);
            case (i)
                0: ifl <= 1;
                1: cd <= 1;
                2: flt <= 1;
                3: cs <= 1;
                default: cs <= 0;
            endcase
            drain();
            {ifl, cd, flt} <= 3'h0;
            tick(1);
        end
        q.push_back(105); ig <= 1; drain();
        ig <= 0; tick(20); ig <= 1; tick(80);
        repeat (2) begin
            lf = lfsr(lf);
            hs <= lf[1:0];
            os <= lf[3:2];
            hlen <= (lf[1:0] + 1) * 10 - 4;
            req <= 1; tick(1); req <= 0; tick(80);
            hlen <= (lf[1:0] + 1) * 10 + 5;
            q.push_back(4); q.push_back(5);
            req <= 1; tick(1); req <= 0; drain();
        end
        print_verdict();
    end
endmodule

// File: hdl/cpa_protect.sv
`timescale 1ns/100ps
// Protection, hiccup, disconnect and alert control of the power path.
module cpa_protect
    import cpa_pkg::*;
#(
    parameter int unsigned DCUT_CYC  = DSCHG_CUT_CYC,
    parameter int unsigned RETRY_CYC = RETRY_WAIT_CYC,
    parameter int unsigned SDLY_CYC  = SHORT_DELAY_CYC,
    parameter int unsigned HIC_CYC   = HICCUP_CYC,
    parameter int unsigned PULSE_CYC = ALERT_PULSE_CYC,
    parameter int unsigned PWD_CYC   = POWER_REPORT_CYC,
    parameter int unsigned HOLD_STEP = HOLD_STEP_CYC,
    parameter int unsigned OFF_STEP  = OFF_STEP_CYC
) (
    input  wire logic             clock_in,
    input  wire logic             rstn_in,
    input  wire logic             discharge_mode_in,
    input  wire logic             supplement_mode_in,
    input  wire logic             bat_over_limit_in,
    input  wire logic             severe_discharge_level_in,
    input  wire logic             battery_undervoltage_in,
    input  wire logic             system_rail_ok_in,
    input  wire logic             in_over_protect_in,
    input  wire logic             input_current_ceiling_in,
    input  wire logic             bat_short_in,
    input  wire logic             input_good_in,
    input  wire logic             input_fault_in,
    input  wire logic             charge_done_in,
    input  wire logic             charge_status_in,
    input  wire logic             fault_in,
    input  wire logic             alert_line_n_in,
    input  wire logic [SET_W-1:0] disconnect_hold_setting_in,
    input  wire logic [SET_W-1:0] disconnect_off_setting_in,
    output logic                  bat_switch_en_out,
    output logic                  bypass_en_out,
    output logic                  reverse_block_fet_en_out,
    output logic                  hiccup_out,
    output logic                  alert_line_n_out,
    output logic                  alert_line_n_oe_out,
    output logic                  alert_bias_low_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);

    function automatic logic [31:0] set_to_cyc(input logic [SET_W-1:0] sel,
                                               input int unsigned step);
        set_to_cyc = 32'((32'(sel) + 32'h1) * step);
    endfunction

    logic [NSENSE-1:0] raw;
    logic [NSENSE-1:0] s;

    assign raw[SB_DSCHG_MODE] = discharge_mode_in;
    assign raw[SB_SUPPL_MODE] = supplement_mode_in;
    assign raw[SB_OVER_LIMIT] = bat_over_limit_in;
    assign raw[SB_SEVERE]     = severe_discharge_level_in;
    assign raw[SB_BAT_UNDERV] = battery_undervoltage_in;
    assign raw[SB_RAIL_OK]    = system_rail_ok_in;
    assign raw[SB_IN_OVER]    = in_over_protect_in;
    assign raw[SB_IN_CEIL]    = input_current_ceiling_in;
    assign raw[SB_BAT_SHORT]  = bat_short_in;
    assign raw[SB_IN_GOOD]    = input_good_in;
    assign raw[SB_IN_FAULT]   = input_fault_in;
    assign raw[SB_CHG_DONE]   = charge_done_in;
    assign raw[SB_CHG_STATUS] = charge_status_in;
    assign raw[SB_FAULT]      = fault_in;
    assign raw[SB_ALERT]      = alert_line_n_in;
    assign raw[SB_HOLD_SET +: SET_W] = disconnect_hold_setting_in;
    assign raw[SB_OFF_SET +: SET_W]  = disconnect_off_setting_in;

    cpa_sync #(.WIDTH(NSENSE)) u_sync (
        .clock_in (clock_in),
        .rstn_in  (rstn_in),
        .d_in     (raw),
        .q_out    (s)
    );

    // Battery discharge current protection.
    logic        mode_act;
    cpa_odc_t    odc_r;
    logic [31:0] odc_cnt_r;

    assign mode_act = s[SB_DSCHG_MODE] | s[SB_SUPPL_MODE];

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            odc_r     <= ODC_ON;
            odc_cnt_r <= '0;
        end else begin
            case (odc_r)
                ODC_ON: begin
                    if (mode_act && s[SB_SEVERE]) begin
                        odc_r     <= ODC_CUT;
                        odc_cnt_r <= '0;
                    end else if (mode_act && s[SB_OVER_LIMIT]) begin
                        if (odc_cnt_r == 32'(DCUT_CYC - 1)) begin
                            odc_r     <= ODC_CUT;
                            odc_cnt_r <= '0;
                        end else begin
                            odc_cnt_r <= odc_cnt_r + 32'h1;
                        end
                    end else begin
                        odc_cnt_r <= '0;
                    end
                end
                ODC_CUT: begin
                    if (odc_cnt_r == 32'(RETRY_CYC - 1)) begin
                        odc_r     <= ODC_ON;
                        odc_cnt_r <= '0;
                    end else begin
                        odc_cnt_r <= odc_cnt_r + 32'h1;
                    end
                end
                default: begin
                    odc_r     <= ODC_ON;
                    odc_cnt_r <= '0;
                end
            endcase
        end
    end

    // Short circuit detection on both paths and the shared hiccup timer.
    logic        armed_r;
    logic        hard_short;
    logic        in_lim;
    logic        bat_lim;
    logic        in_dly_done;
    logic        bat_dly_done;
    logic        hic_go;
    cpa_hic_t    hic_r;
    logic        hic_rvs_r;
    logic [31:0] hic_cnt_r;
    logic [31:0] in_dly_r;
    logic [31:0] bat_dly_r;

    assign hard_short = armed_r & ~s[SB_RAIL_OK] & s[SB_IN_OVER];
    assign in_lim     = ~s[SB_RAIL_OK] & s[SB_IN_CEIL];
    assign bat_lim    = s[SB_OVER_LIMIT];
    assign in_dly_done  = in_lim && in_dly_r == 32'(SDLY_CYC - 1);
    assign bat_dly_done = bat_lim && bat_dly_r == 32'(SDLY_CYC - 1);
    // Whichever path trips first starts the one shared timer.
    assign hic_go = hard_short | s[SB_BAT_SHORT] | in_dly_done
                  | bat_dly_done;

    // Arming drops on each hiccup so the retry may start at full limit.
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            armed_r <= 1'b0;
        end else if (hic_r == HIC_OFF) begin
            armed_r <= 1'b0;
        end else if (s[SB_RAIL_OK]) begin
            armed_r <= 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rstn_in || hic_r != HIC_RUN) begin
            in_dly_r  <= '0;
            bat_dly_r <= '0;
        end else begin
            in_dly_r  <= in_lim && !in_dly_done ? in_dly_r + 32'h1 : '0;
            bat_dly_r <= bat_lim && !bat_dly_done ? bat_dly_r + 32'h1 : '0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            hic_r     <= HIC_RUN;
            hic_rvs_r <= 1'b0;
            hic_cnt_r <= '0;
        end else begin
            case (hic_r)
                HIC_RUN: begin
                    hic_cnt_r <= '0;
                    if (hic_go) begin
                        hic_r     <= HIC_OFF;
                        hic_rvs_r <= hard_short | in_dly_done;
                    end
                end
                HIC_OFF: begin
                    if (hic_cnt_r == 32'(HIC_CYC - 1)) begin
                        hic_r     <= HIC_RUN;
                        hic_rvs_r <= 1'b0;
                        hic_cnt_r <= '0;
                    end else begin
                        hic_cnt_r <= hic_cnt_r + 32'h1;
                    end
                end
                default: begin
                    hic_r     <= HIC_RUN;
                    hic_rvs_r <= 1'b0;
                    hic_cnt_r <= '0;
                end
            endcase
        end
    end

    // Host requested disconnect over the shared alert line.
    cpa_dis_t    dis_r;
    logic [31:0] dis_cnt_r;
    logic [31:0] hold_cyc;
    logic [31:0] off_cyc;
    logic        rel_r;
    logic [2:0]  own_sh_r;
    logic        host_low;
    logic        alert_drv;

    assign hold_cyc = set_to_cyc(s[SB_HOLD_SET +: SET_W], HOLD_STEP);
    assign off_cyc  = set_to_cyc(s[SB_OFF_SET +: SET_W], OFF_STEP);
    // Our own pulse echoes through the synchroniser, so it is masked.
    assign host_low = ~s[SB_ALERT] & ~alert_drv & ~|own_sh_r;

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            own_sh_r <= '0;
        end else begin
            own_sh_r <= {own_sh_r[1:0], alert_drv};
        end
    end

    // A new request needs the line seen high after the last one.
    always_ff @(posedge clock_in) begin
        if (!rstn_in || dis_r == DIS_OFF) begin
            rel_r <= 1'b0;
        end else if (s[SB_ALERT]) begin
            rel_r <= 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            dis_r     <= DIS_IDLE;
            dis_cnt_r <= '0;
        end else begin
            case (dis_r)
                DIS_IDLE: begin
                    if (host_low && rel_r) begin
                        if (dis_cnt_r == hold_cyc - 32'h1) begin
                            dis_r     <= DIS_OFF;
                            dis_cnt_r <= '0;
                        end else begin
                            dis_cnt_r <= dis_cnt_r + 32'h1;
                        end
                    end else begin
                        dis_cnt_r <= '0;
                    end
                end
                DIS_OFF: begin
                    if (dis_cnt_r == off_cyc - 32'h1) begin
                        dis_r     <= DIS_IDLE;
                        dis_cnt_r <= '0;
                    end else begin
                        dis_cnt_r <= dis_cnt_r + 32'h1;
                    end
                end
                default: begin
                    dis_r     <= DIS_IDLE;
                    dis_cnt_r <= '0;
                end
            endcase
        end
    end

    // Event collection for the alert pulse.
    logic        rep_r;
    logic [31:0] pwd_cnt_r;
    logic        rep_evt;
    logic [3:0]  prev_r;
    logic        evt_r;

    assign rep_evt = s[SB_IN_GOOD] != rep_r
                   && pwd_cnt_r == 32'(PWD_CYC - 1);

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            rep_r     <= 1'b0;
            pwd_cnt_r <= '0;
        end else if (s[SB_IN_GOOD] == rep_r || rep_evt) begin
            rep_r     <= s[SB_IN_GOOD];
            pwd_cnt_r <= '0;
        end else begin
            pwd_cnt_r <= pwd_cnt_r + 32'h1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            prev_r <= '0;
            evt_r  <= 1'b0;
        end else begin
            prev_r <= {s[SB_FAULT], s[SB_CHG_STATUS], s[SB_CHG_DONE],
                       s[SB_IN_FAULT]};
            evt_r  <= rep_evt | (s[SB_IN_FAULT] & ~prev_r[0])
                    | (s[SB_CHG_DONE] & ~prev_r[1])
                    | (s[SB_CHG_STATUS] ^ prev_r[2])
                    | (s[SB_FAULT] & ~prev_r[3]);
        end
    end

    // Pulses wait while the line is biased low for the disconnect, except one that starts on the edge the off period begins.
    cpa_pulse #(.WIDTH_CYC(PULSE_CYC)) u_pulse (
        .clock_in   (clock_in),
        .rstn_in    (rstn_in),
        .trig_in    (evt_r),
        .inhibit_in (dis_r == DIS_OFF),
        .drive_out  (alert_drv)
    );

    // Merged switch control; any cut request wins over the enables.
    logic bat_en_r;
    logic byp_en_r;
    logic rvs_en_r;
    logic bias_low_r;

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            bat_en_r <= 1'b1;
            byp_en_r <= 1'b1;
            rvs_en_r <= 1'b1;
        end else begin
            bat_en_r <= !(odc_r == ODC_CUT || s[SB_BAT_UNDERV] || in_lim
                        || hic_r == HIC_OFF
                        || dis_r == DIS_OFF);
            byp_en_r <= !(hic_r == HIC_OFF || dis_r == DIS_OFF);
            rvs_en_r <= !(hic_r == HIC_OFF && hic_rvs_r);
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            bias_low_r <= 1'b0;
        end else begin
            bias_low_r <= dis_r == DIS_OFF;
        end
    end

    assign bat_switch_en_out        = bat_en_r;
    assign bypass_en_out            = byp_en_r;
    assign reverse_block_fet_en_out = rvs_en_r;
    assign hiccup_out               = hic_r == HIC_OFF;
    assign alert_line_n_out         = 1'b0;
    assign alert_line_n_oe_out      = alert_drv;
    assign alert_bias_low_out       = bias_low_r;

    chk_odc_mode_gate: assert property (
        odc_r == ODC_CUT && $past(odc_r) == ODC_ON |-> $past(mode_act))
        else $error("discharge cut outside discharge modes");
    chk_cut_delay_wait: assert property (
        odc_r == ODC_ON && mode_act && s[SB_OVER_LIMIT] && !s[SB_SEVERE]
        && odc_cnt_r < 32'(DCUT_CYC - 1) |=> odc_r == ODC_ON)
        else $error("discharge cut came before its delay");
    chk_retry_resume: assert property (
        odc_r == ODC_CUT && odc_cnt_r == 32'(RETRY_CYC - 1)
        |=> odc_r == ODC_ON)
        else $error("battery switch did not resume after retry");
    chk_severe_cut: assert property (
        odc_r == ODC_ON && mode_act && s[SB_SEVERE]
        |-> ##2 !bat_switch_en_out)
        else $error("severe discharge did not cut at once");
    chk_underv_cut: assert property (
        s[SB_BAT_UNDERV] |=> !bat_switch_en_out)
        else $error("undervoltage left battery switch on");
    chk_hard_short: assert property (
        hic_r == HIC_RUN && hard_short |=> hic_r == HIC_OFF
        ##1 (!bat_switch_en_out && !bypass_en_out
             && !reverse_block_fet_en_out))
        else $error("hard short did not open all switches");
    chk_hiccup_end: assert property (
        hic_r == HIC_OFF && hic_cnt_r == 32'(HIC_CYC - 1)
        |=> hic_r == HIC_RUN)
        else $error("hiccup interval wrong");
    chk_bat_short: assert property (
        hic_r == HIC_RUN && s[SB_BAT_SHORT]
        |-> ##2 (!bat_switch_en_out && !bypass_en_out))
        else $error("battery short did not open switches");
    chk_dis_switches: assert property (
        dis_r == DIS_OFF |=> !bat_switch_en_out && !bypass_en_out)
        else $error("disconnect left a switch on");
    chk_dis_bias: assert property (
        dis_r == DIS_OFF |=> alert_bias_low_out)
        else $error("alert line not biased low in off period");
    chk_report_revert: assert property (
        s[SB_IN_GOOD] != rep_r && pwd_cnt_r < 32'(PWD_CYC - 1)
        |=> $stable(rep_r))
        else $error("input change reported before delay");

    cov_hiccup: cover property (hic_r == HIC_RUN ##1 hic_r == HIC_OFF);
    cov_disconnect: cover property (dis_r == DIS_IDLE ##1 dis_r == DIS_OFF);
    cov_odc_cut: cover property (odc_r == ODC_ON ##1 odc_r == ODC_CUT);
    cov_alert: cover property (!alert_drv ##1 alert_drv);
endmodule

// File: hdl/cpa_pulse.sv
`timescale 1ns/100ps
// Alert pulse generator with one pending event slot.
module cpa_pulse
    import cpa_pkg::*;
#(
    parameter int unsigned WIDTH_CYC = ALERT_PULSE_CYC
) (
    input  wire logic clock_in,
    input  wire logic rstn_in,
    input  wire logic trig_in,
    input  wire logic inhibit_in,
    output logic      drive_out
);
    logic        drv_r;
    logic        pend_r;
    logic [31:0] cnt_r;

    // Events during a pulse are merged into one follow-up pulse.
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            drv_r <= 1'b0;
            cnt_r <= '0;
        end else if (drv_r) begin
            if (cnt_r == 32'(WIDTH_CYC - 1)) begin
                drv_r <= 1'b0;
                cnt_r <= '0;
            end else begin
                cnt_r <= cnt_r + 32'h1;
            end
        end else if ((pend_r || trig_in) && !inhibit_in) begin
            drv_r <= 1'b1;
            cnt_r <= '0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            pend_r <= 1'b0;
        end else if (trig_in && (drv_r || inhibit_in)) begin
            pend_r <= 1'b1;
        end else if (!drv_r && !inhibit_in) begin
            pend_r <= 1'b0;
        end
    end

    assign drive_out = drv_r;

    chk_pulse_hold: assert property (
        @(posedge clock_in) disable iff (!rstn_in)
        drv_r && cnt_r < 32'(WIDTH_CYC - 1) |=> drv_r)
        else $error("alert pulse ended early");
    chk_pulse_end: assert property (
        @(posedge clock_in) disable iff (!rstn_in)
        drv_r && cnt_r == 32'(WIDTH_CYC - 1) |=> !drv_r)
        else $error("alert pulse too long");
endmodule

// File: hdl/cpa_sync.sv
`timescale 1ns/100ps
// Two-flop synchroniser for a vector of pin levels.
module cpa_sync
    import cpa_pkg::*;
#(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clock_in,
    input  wire logic             rstn_in,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] q_r;

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            meta_r <= '0;
            q_r    <= '0;
        end else begin
            meta_r <= d_in;
            q_r    <= meta_r;
        end
    end

    assign q_out = q_r;
endmodule

// File: include/cpa_pkg.sv
// Shared constants and types of the charger protection and alert block.
package cpa_pkg;
    localparam int unsigned CLK_PERIOD_NS    = 4;
    localparam int unsigned SHORT_DELAY_NS   = 60000;
    localparam int unsigned HICCUP_NS        = 800000;
    localparam int unsigned ALERT_PULSE_NS   = 250000;
    localparam int unsigned POWER_REPORT_NS  = 75000000;
    localparam int unsigned DSCHG_CUT_NS     = 100000;
    localparam int unsigned RETRY_WAIT_NS    = 800000;
    localparam int unsigned HOLD_STEP_NS     = 1000000;
    localparam int unsigned OFF_STEP_NS      = 100000000;
    localparam int unsigned SHORT_DELAY_CYC  = SHORT_DELAY_NS / CLK_PERIOD_NS;
    localparam int unsigned HICCUP_CYC       = HICCUP_NS / CLK_PERIOD_NS;
    localparam int unsigned ALERT_PULSE_CYC  = ALERT_PULSE_NS / CLK_PERIOD_NS;
    localparam int unsigned POWER_REPORT_CYC = POWER_REPORT_NS / CLK_PERIOD_NS;
    localparam int unsigned DSCHG_CUT_CYC    = DSCHG_CUT_NS / CLK_PERIOD_NS;
    localparam int unsigned RETRY_WAIT_CYC   = RETRY_WAIT_NS / CLK_PERIOD_NS;
    localparam int unsigned HOLD_STEP_CYC    = HOLD_STEP_NS / CLK_PERIOD_NS;
    localparam int unsigned OFF_STEP_CYC     = OFF_STEP_NS / CLK_PERIOD_NS;
    localparam int unsigned SET_W            = 2;
    localparam int unsigned SB_DSCHG_MODE    = 0;
    localparam int unsigned SB_SUPPL_MODE    = 1;
    localparam int unsigned SB_OVER_LIMIT    = 2;
    localparam int unsigned SB_SEVERE        = 3;
    localparam int unsigned SB_BAT_UNDERV    = 4;
    localparam int unsigned SB_RAIL_OK       = 5;
    localparam int unsigned SB_IN_OVER       = 6;
    localparam int unsigned SB_IN_CEIL       = 7;
    localparam int unsigned SB_BAT_SHORT     = 8;
    localparam int unsigned SB_IN_GOOD       = 9;
    localparam int unsigned SB_IN_FAULT      = 10;
    localparam int unsigned SB_CHG_DONE      = 11;
    localparam int unsigned SB_CHG_STATUS    = 12;
    localparam int unsigned SB_FAULT         = 13;
    localparam int unsigned SB_ALERT         = 14;
    localparam int unsigned SB_HOLD_SET      = 15;
    localparam int unsigned SB_OFF_SET       = 17;
    localparam int unsigned NSENSE           = 19;
    typedef enum logic {ODC_ON, ODC_CUT} cpa_odc_t;
    typedef enum logic {HIC_RUN, HIC_OFF} cpa_hic_t;
    typedef enum logic {DIS_IDLE, DIS_OFF} cpa_dis_t;
endpackage
